//--- pkg/fpm_pkg.sv
// Constants, offsets and types of the flash protection monitor
// Behaviour
// - Thermistor mode disables indicator, routes pin
// - Thermistor below trip raises current interrupt
// - Config2 bit1 picks force torch or shutdown
// - Resume after thermistor: above trip, flags read
// - Thermistor low 250 us before acting
// - Default sync torch forces torch during flash
// - Alternate mode: torch first gives untimed torch
// - Alternate mode: torch after strobe acts normally
// - Supply monitor enable bit0, threshold bits 2:1
// - Config2 bit3 picks torch or off on undervoltage
// - Resume after supply trip: recovered, flags read
// - Supply low 250 us before acting
// - Flash monitor enable bit3, threshold bits 5:4
// - Ramp steps one code per 32 us
// - Flash monitor trip freezes ramp code
// - Flash monitor ignores first two ramp codes
// - Flash comparator low 8 us before halting
// - Halted codes latched, source two high nibble
// - Converter stores higher LED voltage, bits 3:0
// - Bit5 disables converter, default enabled
// - Automatic: flash start clears done, converts
// - Manual: write or read restarts conversion
// - Flags read clears all flags
// - Flag bits: thermistor 5, flash 6, supply 7
// - Sample delay 250 us steps from done low
package fpm_pkg;
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned DEGL_US      = 250;
    localparam int unsigned DEGL_CYC     = DEGL_US * CLK_MHZ;
    localparam int unsigned FDEGL_US     = 8;
    localparam int unsigned FDEGL_CYC    = FDEGL_US * CLK_MHZ;
    localparam int unsigned STEP_US      = 32;
    localparam int unsigned STEP_CYC     = STEP_US * CLK_MHZ;
    localparam int unsigned ADC_STEP_US  = 250;
    localparam int unsigned ADC_STEP_CYC = ADC_STEP_US * CLK_MHZ;

    localparam logic [7:0] OFS_LVOLT   = 8'h30;
    localparam logic [7:0] OFS_ADC_DLY = 8'h31;
    localparam logic [7:0] OFS_SUP     = 8'h80;
    localparam logic [7:0] OFS_LAST    = 8'h81;
    localparam logic [7:0] OFS_FLAGS   = 8'h40;
    localparam logic [7:0] OFS_CFG1    = 8'h41;
    localparam logic [7:0] OFS_CFG2    = 8'h42;

    localparam logic [7:0] RST_LVOLT   = 8'h80;
    localparam logic [7:0] RST_ADC_DLY = 8'hc0;
    localparam logic [7:0] RST_SUP     = 8'hc0;
    localparam logic [7:0] RST_CFG1    = 8'h00;
    localparam logic [7:0] RST_CFG2    = 8'h00;
    localparam logic [7:0] RST_LAST    = 8'h00;

    localparam int CFG1_THERM  = 4;
    localparam int CFG2_T_OFF  = 1;
    localparam int CFG2_ALT    = 2;
    localparam int CFG2_S_OFF  = 3;
    localparam int SUP_EN      = 0;
    localparam int SUP_TH_LSB  = 1;
    localparam int FSUP_EN     = 3;
    localparam int FSUP_TH_LSB = 4;
    localparam int LVOLT_MAN   = 4;
    localparam int LVOLT_DIS   = 5;
    localparam int LVOLT_EOC   = 6;
    localparam int LVOLT_RSV   = 7;
    localparam int FLAG_THERM  = 5;
    localparam int FLAG_FSUP   = 6;
    localparam int FLAG_SUP    = 7;
    localparam int DLY_W       = 5;
    localparam logic [3:0] RAMP_SKIP = 4'h2;

    typedef enum logic [1:0] {
        FPM_IDLE,
        FPM_RAMP,
        FPM_HOLD,
        FPM_TORCH_NT
    } fpm_state_e;
endpackage

//--- rtl/fpm_deglitch.sv
// Comparator deglitch timer that reports a continuous low level
`timescale 1ns/100ps
`default_nettype none
module fpm_deglitch #(
    parameter int unsigned CNT = 2000
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_en,
    input  wire logic i_low,
    output logic      o_hit
);
    localparam int W = $clog2(CNT + 1);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    wire          full = (cnt_ff == W'(CNT));

    assign nxt_cnt = (!i_en || !i_low) ? '0 : (full ? cnt_ff : cnt_ff + W'(1));
    assign o_hit   = full;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    restart_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_low |=> (cnt_ff == '0) && !o_hit)
        else $error("deglitch did not restart");
endmodule
`default_nettype wire

//--- rtl/fpm_top.sv
// Flash protection monitor: thermal, supply, ramp and LED voltage control
`timescale 1ns/100ps
`default_nettype none
module fpm_top #(
    parameter int unsigned P_DEGL_CYC     = fpm_pkg::DEGL_CYC,
    parameter int unsigned P_STEP_CYC     = fpm_pkg::STEP_CYC,
    parameter int unsigned P_ADC_STEP_CYC = fpm_pkg::ADC_STEP_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_strobe,
    input  wire logic       i_sync_torch,
    input  wire logic       i_flash_timeout,
    input  wire logic [3:0] i_flash_code1,
    input  wire logic [3:0] i_flash_code2,
    input  wire logic [3:0] i_torch_code,
    input  wire logic       i_src1_sel,
    input  wire logic       i_src2_sel,
    input  wire logic       i_therm_low,
    input  wire logic       i_sup_low,
    input  wire logic       i_fsup_low,
    input  wire logic [3:0] i_src1_voltage,
    input  wire logic [3:0] i_src2_voltage,
    output logic      [3:0] o_src1_code,
    output logic      [3:0] o_src2_code,
    output logic            o_src1_on,
    output logic            o_src2_on,
    output logic            o_indicator_off,
    output logic            o_pin_to_comparator,
    output logic            o_sup_mon_en,
    output logic      [1:0] o_sup_thresh,
    output logic            o_fsup_mon_en,
    output logic      [1:0] o_fsup_thresh,
    output logic            o_adc_sample
);
    localparam int SW = $clog2(P_STEP_CYC);
    localparam int AW = $clog2(P_ADC_STEP_CYC);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    fpm_pkg::fpm_state_e state_ff;
    fpm_pkg::fpm_state_e nxt_state;

    logic [7:0]    cfg1_ff, cfg2_ff, sup_ff, dly_ff, last_ff, nxt_last, rdata_ff;
    logic [2:0]    flags_ff, nxt_flags;
    logic [3:0]    ramp_ff, nxt_ramp, result_ff, code1_ff, code2_ff;
    logic [SW-1:0] step_ff, nxt_step;
    logic          strobe_ff, man_ff, dis_ff, eoc_ff, nxt_eoc;
    logic          therm_hold_ff, sup_hold_ff, on1_ff, on2_ff, sample_ff;
    logic          busy_ff, nxt_busy;
    localparam int DLY_W_L  = fpm_pkg::DLY_W;
    localparam int FLAG_T_L = fpm_pkg::FLAG_THERM - 5;
    localparam int FLAG_F_L = fpm_pkg::FLAG_FSUP - 5;
    localparam int FLAG_S_L = fpm_pkg::FLAG_SUP - 5;
    logic [AW-1:0] acnt_ff, nxt_acnt;
    logic [DLY_W_L-1:0] astep_ff, nxt_astep;

    // Register decode
    wire hit_lvolt = (i_reg_addr == fpm_pkg::OFS_LVOLT);
    wire hit_dly   = (i_reg_addr == fpm_pkg::OFS_ADC_DLY);
    wire hit_sup   = (i_reg_addr == fpm_pkg::OFS_SUP);
    wire hit_last  = (i_reg_addr == fpm_pkg::OFS_LAST);
    wire hit_flags = (i_reg_addr == fpm_pkg::OFS_FLAGS);
    wire hit_cfg1  = (i_reg_addr == fpm_pkg::OFS_CFG1);
    wire hit_cfg2  = (i_reg_addr == fpm_pkg::OFS_CFG2);
    wire flags_rd  = i_reg_rd && hit_flags;
    wire lvolt_rd  = i_reg_rd && hit_lvolt;
    wire lvolt_wr  = i_reg_wr && hit_lvolt;

    wire [7:0] lv_val   = {fpm_pkg::RST_LVOLT[fpm_pkg::LVOLT_RSV], eoc_ff, dis_ff, man_ff,
                           result_ff};
    wire [7:0] flag_val = {flags_ff, 5'h00};
    wire [7:0] rd_mux   = hit_lvolt ? lv_val   :
                          hit_dly   ? dly_ff   :
                          hit_sup   ? sup_ff   :
                          hit_last  ? last_ff  :
                          hit_flags ? flag_val :
                          hit_cfg1  ? cfg1_ff  :
                          hit_cfg2  ? cfg2_ff  : 8'h00;

    // Mode bits
    wire therm_mode = cfg1_ff[fpm_pkg::CFG1_THERM];
    wire therm_off  = cfg2_ff[fpm_pkg::CFG2_T_OFF];
    wire alt_torch  = cfg2_ff[fpm_pkg::CFG2_ALT];
    wire sup_off    = cfg2_ff[fpm_pkg::CFG2_S_OFF];
    wire sup_en     = sup_ff[fpm_pkg::SUP_EN];
    wire fsup_en    = sup_ff[fpm_pkg::FSUP_EN];

    // Deglitched comparators
    logic therm_hit, sup_hit, fsup_hit;

    fpm_deglitch #(.CNT(P_DEGL_CYC)) u_therm_dg (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_en  (therm_mode),
        .i_low (i_therm_low),
        .o_hit (therm_hit)
    );

    fpm_deglitch #(.CNT(P_DEGL_CYC)) u_sup_dg (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_en  (sup_en),
        .i_low (i_sup_low),
        .o_hit (sup_hit)
    );

    fpm_deglitch #(.CNT(fpm_pkg::FDEGL_CYC)) u_fsup_dg (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_en  (fsup_en && (state_ff == fpm_pkg::FPM_RAMP)),
        .i_low (i_fsup_low),
        .o_hit (fsup_hit)
    );

    wire therm_trip = therm_mode && therm_hit;
    wire sup_trip   = sup_en && sup_hit;

    // Flash sequencing
    wire strobe_rise = i_strobe && !strobe_ff;
    wire untimed     = alt_torch && i_sync_torch;
    wire flash_start = (state_ff == fpm_pkg::FPM_IDLE) && strobe_rise && !untimed;
    wire flash_end   = i_flash_timeout || !i_strobe;
    wire [3:0] tgt1  = i_src1_sel ? i_flash_code1 : 4'h0;
    wire [3:0] tgt2  = i_src2_sel ? i_flash_code2 : 4'h0;
    wire [3:0] tgt   = (tgt1 > tgt2) ? tgt1 : tgt2;
    wire step_done   = (step_ff == SW'(P_STEP_CYC - 1));
    wire halt        = (state_ff == fpm_pkg::FPM_RAMP) && fsup_hit
                       && (ramp_ff >= fpm_pkg::RAMP_SKIP);
    wire [3:0] lvl1  = (ramp_ff < i_flash_code1) ? ramp_ff : i_flash_code1;
    wire [3:0] lvl2  = (ramp_ff < i_flash_code2) ? ramp_ff : i_flash_code2;

    always_comb begin
        nxt_state = state_ff;
        nxt_ramp  = ramp_ff;
        nxt_step  = '0;
        case (state_ff)
            fpm_pkg::FPM_IDLE: begin
                nxt_ramp = 4'h0;
                if (strobe_rise && untimed) begin
                    nxt_state = fpm_pkg::FPM_TORCH_NT;
                end else if (strobe_rise) begin
                    nxt_state = fpm_pkg::FPM_RAMP;
                end
            end
            fpm_pkg::FPM_RAMP: begin
                if (flash_end) begin
                    nxt_state = fpm_pkg::FPM_IDLE;
                end else if (halt || ramp_ff >= tgt) begin
                    nxt_state = fpm_pkg::FPM_HOLD;
                end else if (step_done) begin
                    nxt_ramp = ramp_ff + 4'h1;
                end else begin
                    nxt_step = step_ff + SW'(1);
                end
            end
            fpm_pkg::FPM_HOLD: begin
                if (flash_end) begin
                    nxt_state = fpm_pkg::FPM_IDLE;
                end
            end
            fpm_pkg::FPM_TORCH_NT: begin
                if (!i_sync_torch || !i_strobe) begin
                    nxt_state = fpm_pkg::FPM_IDLE;
                end
            end
            default: begin
                nxt_state = fpm_pkg::FPM_IDLE;
            end
        endcase
    end

    // Current level decision
    wire active     = (state_ff != fpm_pkg::FPM_IDLE);
    wire torch_nt   = (state_ff == fpm_pkg::FPM_TORCH_NT);
    wire force_off  = (therm_hold_ff && therm_off) || (sup_hold_ff && sup_off);
    wire force_tor  = torch_nt || (active && i_sync_torch)
                      || (therm_hold_ff && !therm_off)
                      || (sup_hold_ff && !sup_off);
    wire [3:0] nxt_code1 = force_tor ? i_torch_code : lvl1;
    wire [3:0] nxt_code2 = force_tor ? i_torch_code : lvl2;
    wire nxt_on1 = active && i_src1_sel && !force_off;
    wire nxt_on2 = active && i_src2_sel && !force_off;

    // Flags and hold latches; a set beats a read clear
    assign nxt_flags[FLAG_T_L] = therm_trip || (flags_ff[FLAG_T_L] && !flags_rd);
    assign nxt_flags[FLAG_F_L] = halt || (flags_ff[FLAG_F_L] && !flags_rd);
    assign nxt_flags[FLAG_S_L] = sup_trip || (flags_ff[FLAG_S_L] && !flags_rd);

    wire therm_rel = !i_therm_low && !flags_ff[FLAG_T_L];
    wire sup_rel   = !i_sup_low && !flags_ff[FLAG_S_L];
    assign nxt_last = halt ? {lvl2, lvl1} : last_ff;

    // LED voltage converter
    wire man_wr    = lvolt_wr && i_reg_wdata[fpm_pkg::LVOLT_MAN];
    wire adc_start = !dis_ff && (man_wr
                     || (lvolt_rd && man_ff)
                     || (flash_start && !man_ff));
    wire astep_end = (acnt_ff == AW'(P_ADC_STEP_CYC - 1));
    wire sample    = busy_ff && astep_end
                     && (astep_ff == dly_ff[DLY_W_L-1:0]);
    wire [3:0] vmax = (i_src1_voltage > i_src2_voltage) ? i_src1_voltage
                                                         : i_src2_voltage;

    assign nxt_eoc   = adc_start ? 1'b0 : (sample || (eoc_ff && !lvolt_rd));
    assign nxt_busy  = !dis_ff && (adc_start || (busy_ff && !sample));
    assign nxt_acnt  = (adc_start || astep_end || !busy_ff) ? '0 : acnt_ff + AW'(1);
    assign nxt_astep = adc_start ? '0 : (astep_end ? astep_ff + DLY_W_L'(1) : astep_ff);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff  <= fpm_pkg::FPM_IDLE;
            ramp_ff   <= 4'h0;
            step_ff   <= '0;
            strobe_ff <= 1'b0;
            code1_ff  <= 4'h0;
            code2_ff  <= 4'h0;
            on1_ff    <= 1'b0;
            on2_ff    <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            ramp_ff   <= nxt_ramp;
            step_ff   <= nxt_step;
            strobe_ff <= i_strobe;
            code1_ff  <= nxt_code1;
            code2_ff  <= nxt_code2;
            on1_ff    <= nxt_on1;
            on2_ff    <= nxt_on2;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_ff      <= 3'h0;
            therm_hold_ff <= 1'b0;
            sup_hold_ff   <= 1'b0;
            last_ff       <= fpm_pkg::RST_LAST;
        end else begin
            flags_ff      <= nxt_flags;
            therm_hold_ff <= therm_trip || (therm_hold_ff && !therm_rel);
            sup_hold_ff   <= sup_trip || (sup_hold_ff && !sup_rel);
            last_ff       <= nxt_last;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            eoc_ff    <= fpm_pkg::RST_LVOLT[fpm_pkg::LVOLT_EOC];
            busy_ff   <= 1'b0;
            acnt_ff   <= '0;
            astep_ff  <= '0;
            result_ff <= fpm_pkg::RST_LVOLT[3:0];
            sample_ff <= 1'b0;
        end else begin
            eoc_ff    <= nxt_eoc;
            busy_ff   <= nxt_busy;
            acnt_ff   <= nxt_acnt;
            astep_ff  <= nxt_astep;
            result_ff <= sample ? vmax : result_ff;
            sample_ff <= sample;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg1_ff  <= fpm_pkg::RST_CFG1;
            cfg2_ff  <= fpm_pkg::RST_CFG2;
            sup_ff   <= fpm_pkg::RST_SUP;
            dly_ff   <= fpm_pkg::RST_ADC_DLY;
            man_ff   <= fpm_pkg::RST_LVOLT[fpm_pkg::LVOLT_MAN];
            dis_ff   <= fpm_pkg::RST_LVOLT[fpm_pkg::LVOLT_DIS];
            rdata_ff <= 8'h00;
        end else begin
            cfg1_ff  <= (i_reg_wr && hit_cfg1) ? i_reg_wdata : cfg1_ff;
            cfg2_ff  <= (i_reg_wr && hit_cfg2) ? i_reg_wdata : cfg2_ff;
            sup_ff   <= (i_reg_wr && hit_sup) ? i_reg_wdata : sup_ff;
            dly_ff   <= (i_reg_wr && hit_dly) ? i_reg_wdata : dly_ff;
            man_ff   <= lvolt_wr ? i_reg_wdata[fpm_pkg::LVOLT_MAN] : man_ff;
            dis_ff   <= lvolt_wr ? i_reg_wdata[fpm_pkg::LVOLT_DIS] : dis_ff;
            rdata_ff <= i_reg_rd ? rd_mux : rdata_ff;
        end
    end

    // Output drive; thresholds map code 0 to 2.9V rising 0.1V per code
    assign o_reg_rdata         = rdata_ff;
    assign o_src1_code         = code1_ff;
    assign o_src2_code         = code2_ff;
    assign o_src1_on           = on1_ff;
    assign o_src2_on           = on2_ff;
    assign o_indicator_off     = cfg1_ff[fpm_pkg::CFG1_THERM];
    assign o_pin_to_comparator = cfg1_ff[fpm_pkg::CFG1_THERM];
    assign o_sup_mon_en        = sup_ff[fpm_pkg::SUP_EN];
    assign o_sup_thresh        = sup_ff[fpm_pkg::SUP_TH_LSB +: 2];
    assign o_fsup_mon_en       = sup_ff[fpm_pkg::FSUP_EN];
    assign o_fsup_thresh       = sup_ff[fpm_pkg::FSUP_TH_LSB +: 2];
    assign o_adc_sample        = sample_ff;

    therm_route_a: assert property (
        (i_reg_wr && hit_cfg1 && i_reg_wdata[fpm_pkg::CFG1_THERM])
        |=> o_indicator_off && o_pin_to_comparator)
        else $error("thermistor pin routing missing");
    therm_flag_a: assert property (
        therm_mode && therm_hit |=> flags_ff[FLAG_T_L] && therm_hold_ff)
        else $error("thermistor flag not set");
    therm_off_a: assert property (
        therm_hold_ff && therm_off && !i_rst |=> !o_src1_on && !o_src2_on)
        else $error("thermistor shutdown not applied");
    therm_keep_a: assert property (
        therm_hold_ff && (i_therm_low || flags_ff[FLAG_T_L]) |=> therm_hold_ff)
        else $error("thermistor hold released early");
    sup_keep_a: assert property (
        sup_hold_ff && (i_sup_low || flags_ff[FLAG_S_L]) |=> sup_hold_ff)
        else $error("supply hold released early");
    ramp_step_a: assert property (
        (state_ff == fpm_pkg::FPM_RAMP) && (ramp_ff != $past(ramp_ff))
        && ($past(state_ff) == fpm_pkg::FPM_RAMP) |-> ramp_ff == $past(ramp_ff) + 4'h1)
        else $error("ramp skipped a code");
    halt_skip_a: assert property (
        flags_ff[FLAG_F_L] && !$past(flags_ff[FLAG_F_L]) |-> $past(ramp_ff) >= 4'h2)
        else $error("flash monitor halted too early");
    last_code_a: assert property (
        halt |=> last_ff == {$past(lvl2), $past(lvl1)} && state_ff != fpm_pkg::FPM_RAMP)
        else $error("halted code not latched");
    flags_clr_a: assert property (
        flags_rd && !therm_trip && !sup_trip && !halt |=> flags_ff == 3'h0)
        else $error("flags not cleared by read");
    eoc_start_a: assert property (
        adc_start |=> !eoc_ff && busy_ff)
        else $error("conversion start did not clear done");
endmodule
`default_nettype wire

//--- tb/fpm_far_side.sv
// Far-side model: LED forward voltages, thermistor and supply comparators
`timescale 1ns/100ps
`default_nettype none
module fpm_far_side #(
    parameter logic [3:0] P_VF1 = 4'h9,
    parameter logic [3:0] P_VF2 = 4'h6
) (
    input  wire logic       i_src1_on,
    input  wire logic       i_src2_on,
    input  wire logic       i_hot,
    input  wire logic       i_sag,
    input  wire logic       i_dip,
    output logic      [3:0] o_vf1,
    output logic      [3:0] o_vf2,
    output logic            o_therm_low,
    output logic            o_sup_low,
    output logic            o_fsup_low
);
    // A dark LED shows no forward voltage
    assign o_vf1       = i_src1_on ? P_VF1 : 4'h0;
    assign o_vf2       = i_src2_on ? P_VF2 : 4'h0;
    assign o_therm_low = i_hot;
    assign o_sup_low   = i_sag;
    assign o_fsup_low  = i_dip;
endmodule
`default_nettype wire

//--- tb/fpm_top_bench.sv
// Self-checking bench of the flash protection monitor
`timescale 1ns/100ps
`default_nettype none
module fpm_top_bench;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} fpm_row_s;
    logic       i_clk, i_rst, i_reg_wr, i_reg_rd, i_strobe, i_sync_torch, i_flash_timeout;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [3:0] i_flash_code1, i_flash_code2, i_torch_code, o_src1_code, o_src2_code, vf1, vf2;
    logic       i_src1_sel, i_src2_sel, therm_low, sup_low, fsup_low, hot, sag, dip;
    logic       o_src1_on, o_src2_on, o_indicator_off, o_pin_to_comparator;
    logic       o_sup_mon_en, o_fsup_mon_en, o_adc_sample;
    logic [1:0] o_sup_thresh, o_fsup_thresh;
    int         error_cnt = 0;
    int         n_compared = 0;
    fpm_row_s   rows [12];

    fpm_top #(.P_DEGL_CYC(20), .P_STEP_CYC(200), .P_ADC_STEP_CYC(8)) uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_strobe(i_strobe), .i_sync_torch(i_sync_torch), .i_flash_timeout(i_flash_timeout),
        .i_flash_code1(i_flash_code1), .i_flash_code2(i_flash_code2),
        .i_torch_code(i_torch_code), .i_src1_sel(i_src1_sel), .i_src2_sel(i_src2_sel),
        .i_therm_low(therm_low), .i_sup_low(sup_low), .i_fsup_low(fsup_low),
        .i_src1_voltage(vf1), .i_src2_voltage(vf2), .o_src1_code(o_src1_code),
        .o_src2_code(o_src2_code), .o_src1_on(o_src1_on), .o_src2_on(o_src2_on),
        .o_indicator_off(o_indicator_off), .o_pin_to_comparator(o_pin_to_comparator),
        .o_sup_mon_en(o_sup_mon_en), .o_sup_thresh(o_sup_thresh),
        .o_fsup_mon_en(o_fsup_mon_en), .o_fsup_thresh(o_fsup_thresh),
        .o_adc_sample(o_adc_sample));

    fpm_far_side far (
        .i_src1_on(o_src1_on), .i_src2_on(o_src2_on), .i_hot(hot), .i_sag(sag),
        .i_dip(dip), .o_vf1(vf1), .o_vf2(vf2), .o_therm_low(therm_low),
        .o_sup_low(sup_low), .o_fsup_low(fsup_low));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk("reg read", o_reg_rdata, e);
    endtask

    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge i_clk);
        error_cnt++;
        stop_test();
    end

    initial begin
        {i_reg_wr, i_reg_rd, i_strobe, i_sync_torch, i_flash_timeout, hot, sag, dip} = '0;
        {i_reg_addr, i_reg_wdata} = '0;
        {i_flash_code1, i_flash_code2, i_torch_code} = {4'h5, 4'h3, 4'h2};
        {i_src1_sel, i_src2_sel} = 2'b11;
        i_rst = 1'b1;
        rows = '{{1'b0, 8'h30, 8'h00, 8'h80}, {1'b0, 8'h31, 8'h00, 8'hc0},
                 {1'b0, 8'h80, 8'h00, 8'hc0}, {1'b0, 8'h81, 8'h00, 8'h00},
                 {1'b0, 8'h40, 8'h00, 8'h00}, {1'b0, 8'h41, 8'h00, 8'h00},
                 {1'b0, 8'h42, 8'h00, 8'h00}, {1'b0, 8'h55, 8'h00, 8'h00},
                 {1'b1, 8'h81, 8'hff, 8'h00}, {1'b0, 8'h81, 8'h00, 8'h00},
                 {1'b1, 8'h41, 8'h10, 8'h00}, {1'b0, 8'h41, 8'h00, 8'h10}};
        cyc(3);
        @(posedge i_clk) i_rst <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            if (rows[k].wr) wr(rows[k].addr, rows[k].data);
            else rdc(rows[k].addr, rows[k].exp);
        end
        chk("pin route", {6'h0, o_indicator_off, o_pin_to_comparator}, 8'h03);
        // Flash ramp, automatic conversion, sync torch, timeout
        @(posedge i_clk) i_strobe <= 1'b1;
        cyc(3);
        chk("first code", {4'h0, o_src1_code}, 8'h00);
        cyc(1100);
        chk("held codes", {o_src2_code, o_src1_code}, 8'h35);
        rdc(8'h30, 8'hc9);
        rdc(8'h30, 8'h89);
        @(posedge i_clk) i_sync_torch <= 1'b1;
        cyc(4);
        chk("sync torch", {4'h0, o_src1_code}, 8'h02);
        @(posedge i_clk) i_sync_torch <= 1'b0;
        cyc(4);
        chk("flash back", {4'h0, o_src1_code}, 8'h05);
        @(posedge i_clk) i_flash_timeout <= 1'b1;
        @(posedge i_clk) i_flash_timeout <= 1'b0;
        cyc(4);
        chk("timeout off", {6'h0, o_src1_on, o_src2_on}, 8'h00);
        @(posedge i_clk) i_strobe <= 1'b0;
        // Thermistor deglitch restart, force torch, recovery
        cyc(2);
        @(posedge i_clk) i_strobe <= 1'b1;
        cyc(1100);
        @(posedge i_clk) hot <= 1'b1;
        cyc(15);
        @(posedge i_clk) hot <= 1'b0;
        rdc(8'h40, 8'h00);
        @(posedge i_clk) hot <= 1'b1;
        cyc(30);
        chk("therm torch", {4'h0, o_src1_code}, 8'h02);
        @(posedge i_clk) hot <= 1'b0;
        cyc(4);
        chk("therm stays", {4'h0, o_src1_code}, 8'h02);
        rdc(8'h40, 8'h20);
        cyc(4);
        chk("therm resume", {4'h0, o_src1_code}, 8'h05);
        // Supply monitor off and torch, thermistor off, resume
        wr(8'h42, 8'h08);
        wr(8'h80, 8'h03);
        cyc(1);
        chk("sup cfg", {5'h0, o_sup_thresh, o_sup_mon_en}, 8'h03);
        @(posedge i_clk) sag <= 1'b1;
        cyc(30);
        chk("sup off", {6'h0, o_src1_on, o_src2_on}, 8'h00);
        wr(8'h42, 8'h02);
        cyc(2);
        chk("sup torch", {o_src2_code, o_src1_code}, 8'h22);
        chk("sup torch on", {6'h0, o_src1_on, o_src2_on}, 8'h03);
        @(posedge i_clk) hot <= 1'b1;
        cyc(30);
        chk("therm off", {6'h0, o_src1_on, o_src2_on}, 8'h00);
        @(posedge i_clk) {hot, sag} <= 2'b00;
        rdc(8'h40, 8'ha0);
        cyc(4);
        chk("sup resume", {6'h0, o_src1_on, o_src2_on}, 8'h03);
        @(posedge i_clk) i_strobe <= 1'b0;
        // Alternate torch: torch before strobe is untimed
        wr(8'h42, 8'h04);
        @(posedge i_clk) i_sync_torch <= 1'b1;
        cyc(2);
        @(posedge i_clk) i_strobe <= 1'b1;
        cyc(6);
        chk("alt torch", {4'h0, o_src1_code}, 8'h02);
        @(posedge i_clk) i_flash_timeout <= 1'b1;
        @(posedge i_clk) i_flash_timeout <= 1'b0;
        cyc(4);
        chk("alt untimed", {6'h0, o_src1_on, o_src2_on}, 8'h03);
        @(posedge i_clk) i_sync_torch <= 1'b0;
        @(posedge i_clk) i_strobe <= 1'b0;
        // Alternate torch: torch after strobe is timed
        cyc(2);
        @(posedge i_clk) i_strobe <= 1'b1;
        cyc(4);
        @(posedge i_clk) i_sync_torch <= 1'b1;
        cyc(4);
        chk("alt late", {o_src2_code, o_src1_code}, 8'h22);
        @(posedge i_clk) i_flash_timeout <= 1'b1;
        @(posedge i_clk) {i_flash_timeout, i_sync_torch} <= 2'b00;
        cyc(4);
        chk("alt timeout", {6'h0, o_src1_on, o_src2_on}, 8'h00);
        @(posedge i_clk) i_strobe <= 1'b0;
        // Supply flash monitor halts ramp at code ten
        wr(8'h42, 8'h00);
        wr(8'h80, 8'h18);
        {i_flash_code1, i_flash_code2} <= 8'hff;
        cyc(2);
        chk("fsup cfg", {5'h0, o_fsup_thresh, o_fsup_mon_en}, 8'h03);
        @(posedge i_clk) i_strobe <= 1'b1;
        cyc(100);
        @(posedge i_clk) dip <= 1'b1;
        cyc(3500);
        chk("halt code", {o_src2_code, o_src1_code}, 8'haa);
        rdc(8'h81, 8'haa);
        rdc(8'h40, 8'h40);
        @(posedge i_clk) dip <= 1'b0;
        @(posedge i_clk) i_strobe <= 1'b0;
        // Manual conversion with sources dark
        wr(8'h30, 8'h10);
        cyc(20);
        rdc(8'h30, 8'hd0);
        rdc(8'h30, 8'h90);
        cyc(7);
        chk("adc idle", {7'h0, o_adc_sample}, 8'h00);
        cyc(1);
        chk("adc pulse", {7'h0, o_adc_sample}, 8'h01);
        // Reset in mid-run
        @(posedge i_clk) i_rst <= 1'b1;
        cyc(4);
        chk("reset codes", {o_src2_code, o_src1_code}, 8'h00);
        chk("reset rdata", o_reg_rdata, 8'h00);
        chk("reset outs", {o_src1_on, o_src2_on, o_indicator_off, o_sup_mon_en,
                           o_fsup_mon_en, o_adc_sample, o_fsup_thresh}, 8'h00);
        @(posedge i_clk) i_rst <= 1'b0;
        rdc(8'h30, 8'h80);
        stop_test();
    end
endmodule
`default_nettype wire
